// ---- cpmc_pkg.sv ----
package cpmc_pkg;

  // Number of controller interfaces that may be configured active.
  localparam int unsigned CPMC_MAX_IFS   = 4;
  localparam int unsigned CPMC_IF_W      = 2;
  // Job management storage: one entry per job, indexed by job number.
  localparam int unsigned CPMC_JOBS      = 128;
  localparam int unsigned CPMC_JOB_W     = 7;
  // Self-test duration in clock cycles.
  localparam int unsigned CPMC_TEST_CYC  = 16;
  localparam logic [4:0]  CPMC_TEST_LAST = 5'h0F;
  // Last count of the warm-restart sweep; the sweep lasts 8 cycles.
  localparam logic [3:0]  CPMC_WARM_LAST = 4'h7;
  // Register offsets of the plain register port.
  localparam logic [3:0]  CPMC_REG_STATUS = 4'h0;
  localparam logic [3:0]  CPMC_REG_MODE   = 4'h1;
  localparam logic [3:0]  CPMC_REG_EVENT  = 4'h2;
  localparam logic [3:0]  CPMC_REG_MASK   = 4'h3;
  localparam logic [3:0]  CPMC_REG_CTRL   = 4'h4;
  // Event bit positions.
  localparam int unsigned CPMC_EV_RUN    = 0;
  localparam int unsigned CPMC_EV_STOP   = 1;
  localparam int unsigned CPMC_EV_FAULT  = 2;
  localparam int unsigned CPMC_EV_SUPPLY = 3;
  localparam int unsigned CPMC_EV_W      = 4;
  localparam logic [3:0]  CPMC_MASK_RST  = 4'h0;
  // Mode code width in the status register.
  localparam int unsigned CPMC_ST_W      = 3;

  typedef enum logic [2:0] {
    CPMC_SELFTEST,
    CPMC_BUILD,
    CPMC_IDLE,
    CPMC_STOP,
    CPMC_WARM,
    CPMC_RUN,
    CPMC_FAULT
  } cpmc_state_t;

endpackage

// ---- cpmc_ctrl.sv ----
// Notes on behaviour
// - Self-test first: run off, stop on.
// - Build one management entry per job.
// - Idle: system jobs, programmer on, traffic off.
// - Idle until all active interfaces synchronized.
// - Leave idle to selector position.
// - Stop: programs on, links kept, transfer blocked.
// - Run: everything on except database alteration.
// - Stop to run: warm restart, flush.
// - Run only if selector and programmer run.
// - Selector stop cleared only by selector.
// - Run requests ignored while unsynchronized.
// - Fault: all off, stop and fault lit.
// - Run: run lit, tests permitted.
// - Stop: only stop lit, tests refused.
// - Supply fault indicator when supply missing.
// - Every power-up takes the full path.
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cpmc_ctrl
  import cpmc_pkg::*;
(
  // Clock and reset.
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Front panel and rack pins, asynchronous.
  input  wire logic                  selector_run,
  input  wire logic                  supply_ok,
  input  wire logic                  hw_fault,
  // Self-test result and stored job parameters.
  input  wire logic                  selftest_pass,
  input  wire logic [CPMC_JOB_W-1:0] jobs_defined,
  input  wire logic [CPMC_IF_W-1:0]  active_ifs_m1,
  // Synchronization calls from the master, one strobe per interface.
  input  wire logic [CPMC_MAX_IFS-1:0] interface_sync_call,
  // Programmer start and stop requests.
  input  wire logic                  pgm_start_req,
  input  wire logic                  pgm_stop_req,
  // Register port.
  input  wire logic [3:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [7:0]            reg_rdata,
  // Enables towards the rest of the processor.
  output logic                       system_jobs_en,
  output logic                       programming_device_en,
  output logic                       pgm_test_en,
  output logic                       db_alter_en,
  output logic                       plc_if_en,
  output logic                       bus_xfer_en,
  output logic                       links_keep,
  output logic                       links_drop,
  output logic                       buffers_flush,
  // Indicators.
  output logic                       run_indicator,
  output logic                       stop_indicator,
  output logic                       module_fault_indicator,
  output logic                       bus_fault_indicator,
  output logic                       transceiver_supply_fault_indicator,
  // Interrupt.
  output logic                       irq
);

  cpmc_state_t                state;
  cpmc_state_t                next_state;
  logic [1:0]                 sel_sync;
  logic [1:0]                 sup_sync;
  logic [1:0]                 flt_sync;
  logic [4:0]                 test_cnt;
  logic [CPMC_JOB_W-1:0]      build_idx;
  logic [CPMC_JOBS-1:0]       job_management_field;
  logic [CPMC_MAX_IFS-1:0]    synced;
  logic [CPMC_MAX_IFS-1:0]    needed;
  logic                       all_synced;
  logic                       pgm_run;
  logic                       sel_stop_latched;
  logic                       want_run;
  logic [3:0]                 warm_cnt;
  logic [CPMC_EV_W-1:0]       ev_status;
  logic [CPMC_EV_W-1:0]       ev_mask;
  logic [CPMC_EV_W-1:0]       ev_set;
  logic                       sw_stop;
  logic                       prev_run;
  logic                       prev_stop;

  // Pin inputs pass two flip-flops before any logic reads them.
  // The supply sense resets to present, so release shows no false supply loss.
  always_ff @(posedge clk) begin
    if (rst) begin
      sel_sync <= 2'h0;
      sup_sync <= 2'h3;
      flt_sync <= 2'h0;
    end else begin
      sel_sync <= {sel_sync[0], selector_run};
      sup_sync <= {sup_sync[0], supply_ok};
      flt_sync <= {flt_sync[0], hw_fault};
    end
  end

  // Interfaces that must be synchronized, one to four of them.
  generate
    for (genvar i = 0; i < CPMC_MAX_IFS; i++) begin : g_need
      assign needed[i] = (active_ifs_m1 >= CPMC_IF_W'(i));
    end
  endgenerate
  assign all_synced = ((synced & needed) == needed);

  // Self-test cycle counter.
  always_ff @(posedge clk) begin
    if (rst || state != CPMC_SELFTEST) begin
      test_cnt <= 5'h00;
    end else if (test_cnt != CPMC_TEST_LAST) begin
      test_cnt <= test_cnt + 5'h01;
    end
  end

  // Management entries are built one per cycle for each defined job.
  always_ff @(posedge clk) begin
    if (rst) begin
      build_idx            <= '0;
      job_management_field <= '0;
    end else if (state == CPMC_BUILD) begin
      if (build_idx != jobs_defined) begin
        job_management_field[build_idx] <= 1'b1;
        build_idx <= build_idx + CPMC_JOB_W'(1);
      end
    end else if (state == CPMC_SELFTEST) begin
      build_idx            <= '0;
      job_management_field <= '0;
    end
  end

  // Synchronization marks, collected only while unsynchronized.
  always_ff @(posedge clk) begin
    if (rst || state == CPMC_SELFTEST) begin
      synced <= '0;
    end else if (state == CPMC_IDLE) begin
      synced <= synced | interface_sync_call;
    end
  end

  // Latest programmer request; a run request is ignored while idle.
  always_ff @(posedge clk) begin
    if (rst) begin
      pgm_run <= 1'b1;
    end else if (pgm_stop_req || sw_stop) begin
      pgm_run <= 1'b0;
    end else if (pgm_start_req && state != CPMC_IDLE && state != CPMC_BUILD
                 && state != CPMC_SELFTEST) begin
      pgm_run <= 1'b1;
    end
  end

  // A selector stop holds until the selector itself returns to run.
  always_ff @(posedge clk) begin
    if (rst) begin
      sel_stop_latched <= 1'b0;
    end else begin
      sel_stop_latched <= !sel_sync[1];
    end
  end
  assign want_run = sel_sync[1] && !sel_stop_latched && pgm_run;

  // Warm-restart sweep length.
  always_ff @(posedge clk) begin
    if (rst || state != CPMC_WARM) begin
      warm_cnt <= 4'h0;
    end else begin
      warm_cnt <= warm_cnt + 4'h1;
    end
  end

  // Mode sequencing.
  always_comb begin
    next_state = state;
    case (state)
      CPMC_SELFTEST: begin
        if (flt_sync[1]) begin
          next_state = CPMC_FAULT;
        end else if (test_cnt == CPMC_TEST_LAST) begin
          next_state = selftest_pass ? CPMC_BUILD : CPMC_FAULT;
        end
      end
      CPMC_BUILD: begin
        if (build_idx == jobs_defined) begin
          next_state = CPMC_IDLE;
        end
      end
      CPMC_IDLE: begin
        if (all_synced) begin
          next_state = sel_sync[1] ? CPMC_WARM : CPMC_STOP;
        end
      end
      CPMC_STOP: begin
        if (want_run) begin
          next_state = CPMC_WARM;
        end
      end
      CPMC_WARM: begin
        if (!want_run) begin
          next_state = CPMC_STOP;
        end else if (warm_cnt == CPMC_WARM_LAST) begin
          next_state = CPMC_RUN;
        end
      end
      CPMC_RUN: begin
        if (!want_run) begin
          next_state = CPMC_STOP;
        end
      end
      CPMC_FAULT: next_state = CPMC_FAULT;
      default:    next_state = CPMC_SELFTEST;
    endcase
    if (flt_sync[1] && state != CPMC_SELFTEST) begin
      next_state = CPMC_FAULT;
    end
  end

  // State register; reset returns to self-test.
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= CPMC_SELFTEST;
    end else begin
      state <= next_state;
    end
  end

  // Enables and indicators per mode, registered.
  always_ff @(posedge clk) begin
    if (rst) begin
      system_jobs_en         <= 1'b0;
      programming_device_en  <= 1'b0;
      pgm_test_en            <= 1'b0;
      db_alter_en            <= 1'b0;
      plc_if_en              <= 1'b0;
      bus_xfer_en            <= 1'b0;
      links_keep             <= 1'b0;
      links_drop             <= 1'b0;
      buffers_flush          <= 1'b0;
      run_indicator          <= 1'b0;
      stop_indicator         <= 1'b1;
      module_fault_indicator <= 1'b0;
      bus_fault_indicator    <= 1'b0;
    end else begin
      system_jobs_en        <= next_state inside {CPMC_IDLE, CPMC_STOP, CPMC_WARM,
                                                  CPMC_RUN};
      programming_device_en <= next_state inside {CPMC_IDLE, CPMC_STOP, CPMC_WARM,
                                                  CPMC_RUN};
      pgm_test_en           <= (next_state == CPMC_RUN);
      db_alter_en           <= (next_state == CPMC_STOP);
      plc_if_en             <= (next_state == CPMC_RUN);
      bus_xfer_en           <= (next_state == CPMC_RUN);
      links_keep            <= next_state inside {CPMC_STOP, CPMC_RUN};
      links_drop            <= (next_state == CPMC_WARM);
      buffers_flush         <= (next_state == CPMC_WARM);
      run_indicator         <= next_state inside {CPMC_IDLE, CPMC_RUN};
      stop_indicator        <= (next_state != CPMC_RUN);
      module_fault_indicator <= (next_state == CPMC_FAULT);
      bus_fault_indicator   <= 1'b0;
    end
  end

  // Supply fault indicator follows the synchronised supply sense.
  always_ff @(posedge clk) begin
    if (rst) begin
      transceiver_supply_fault_indicator <= 1'b0;
    end else begin
      transceiver_supply_fault_indicator <= !sup_sync[1];
    end
  end

  // Event sources, one pulse per run or stop entry, fault onset or supply loss.
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_run  <= 1'b0;
      prev_stop <= 1'b0;
    end else begin
      prev_run  <= (state == CPMC_RUN);
      prev_stop <= (state == CPMC_STOP);
    end
  end
  assign ev_set[CPMC_EV_RUN]    = (state == CPMC_RUN) && !prev_run;
  assign ev_set[CPMC_EV_STOP]   = (state == CPMC_STOP) && !prev_stop;
  assign ev_set[CPMC_EV_FAULT]  = (next_state == CPMC_FAULT) && (state != CPMC_FAULT);
  assign ev_set[CPMC_EV_SUPPLY] = !sup_sync[1] && !transceiver_supply_fault_indicator;

  // Sticky events; a read clears them, but a set in the same cycle wins.
  always_ff @(posedge clk) begin
    if (rst) begin
      ev_status <= '0;
    end else if (reg_rd && reg_addr == CPMC_REG_EVENT) begin
      ev_status <= ev_set;
    end else begin
      ev_status <= ev_status | ev_set;
    end
  end

  // Mask register and software stop control.
  always_ff @(posedge clk) begin
    if (rst) begin
      ev_mask <= CPMC_MASK_RST;
      sw_stop <= 1'b0;
    end else begin
      sw_stop <= reg_wr && reg_addr == CPMC_REG_CTRL && reg_wdata[0];
      if (reg_wr && reg_addr == CPMC_REG_MASK) begin
        ev_mask <= reg_wdata[CPMC_EV_W-1:0];
      end
    end
  end

  assign irq = |(ev_status & ev_mask);

  // Read data stand in the cycle after the read strobe.
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        CPMC_REG_STATUS: reg_rdata <= {5'h00, state};
        CPMC_REG_MODE:   reg_rdata <= {2'h0, sel_sync[1], pgm_run, synced};
        CPMC_REG_EVENT:  reg_rdata <= {4'h0, ev_status};
        CPMC_REG_MASK:   reg_rdata <= {4'h0, ev_mask};
        default:         reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// ---- cpmc_ctrl_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpmc_ctrl_sva (
  // Clock, reset and watched pins.
  input wire logic clk,
  input wire logic rst,
  input wire logic selector_run,
  input wire logic supply_ok,
  // Enables and indicators.
  input wire logic system_jobs_en,
  input wire logic programming_device_en,
  input wire logic pgm_test_en,
  input wire logic db_alter_en,
  input wire logic plc_if_en,
  input wire logic bus_xfer_en,
  input wire logic links_drop,
  input wire logic buffers_flush,
  input wire logic run_indicator,
  input wire logic stop_indicator,
  input wire logic module_fault_indicator,
  input wire logic bus_fault_indicator,
  input wire logic transceiver_supply_fault_indicator
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Mode relations between the enables, the indicators and the pins.
  property p_rst_off;
    $fell(rst) |-> !system_jobs_en && !programming_device_en && !plc_if_en;
  endproperty
  property p_selftest;
    $fell(rst) |-> (stop_indicator && !run_indicator && !module_fault_indicator) [*8];
  endproperty
  property p_idle;
    run_indicator && stop_indicator |->
      (system_jobs_en && programming_device_en && !plc_if_en && !bus_xfer_en) ##1 !bus_xfer_en;
  endproperty
  property p_run_en;
    bus_xfer_en |-> plc_if_en && system_jobs_en && programming_device_en && !db_alter_en;
  endproperty
  property p_run_led;
    bus_xfer_en |-> run_indicator && !stop_indicator && !module_fault_indicator && pgm_test_en;
  endproperty
  property p_stop;
    programming_device_en && !run_indicator && !links_drop |-> stop_indicator && !bus_xfer_en
      && !plc_if_en && !pgm_test_en && !bus_fault_indicator && !module_fault_indicator;
  endproperty
  property p_fault;
    module_fault_indicator |-> (stop_indicator && !run_indicator && !system_jobs_en
      && !programming_device_en && !plc_if_en) ##1 module_fault_indicator;
  endproperty
  property p_warm;
    $rose(bus_xfer_en) |-> $past(links_drop) && $past(buffers_flush);
  endproperty
  property p_sel_stop;
    !selector_run [*5] |-> !bus_xfer_en;
  endproperty
  property p_supply;
    $stable(supply_ok) [*5] |-> transceiver_supply_fault_indicator == !supply_ok;
  endproperty
  a_rst_off: assert property (p_rst_off) else $error("enables on after reset");
  a_selftest: assert property (p_selftest) else $error("self-test lamps wrong");
  a_idle: assert property (p_idle) else $error("idle enables wrong");
  a_run_en: assert property (p_run_en) else $error("run enables wrong");
  a_run_led: assert property (p_run_led) else $error("run lamps wrong");
  a_stop: assert property (p_stop) else $error("stop outputs wrong");
  a_fault: assert property (p_fault) else $error("fault outputs wrong");
  a_warm: assert property (p_warm) else $error("run without warm restart");
  a_sel_stop: assert property (p_sel_stop) else $error("transfer with selector at stop");
  a_supply: assert property (p_supply) else $error("supply lamp wrong");
  c_run: cover property (bus_xfer_en);
  c_warm: cover property ($rose(links_drop));
  c_fault: cover property (module_fault_indicator);
endmodule
bind cpmc_ctrl cpmc_ctrl_sva u_sva (.clk, .rst, .selector_run, .supply_ok, .system_jobs_en,
  .programming_device_en, .pgm_test_en, .db_alter_en, .plc_if_en, .bus_xfer_en, .links_drop,
  .buffers_flush, .run_indicator, .stop_indicator, .module_fault_indicator, .bus_fault_indicator,
  .transceiver_supply_fault_indicator);
`default_nettype wire

// ---- cpmc_master_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpmc_master_model
  import cpmc_pkg::*;
(
  // Clock and reset.
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Command from the bench.
  input  wire logic                    go,
  input  wire logic                    slow,
  input  wire logic [CPMC_MAX_IFS-1:0] sel,
  // Synchronization calls towards the device.
  output logic      [CPMC_MAX_IFS-1:0] interface_sync_call
);
  logic [11:0] dly;
  // One pulse per chosen interface, either at once or three cycles late.
  always_ff @(posedge clk) begin
    if (rst) begin
      dly <= 12'h000;
      interface_sync_call <= 4'h0;
    end else begin
      dly <= {dly[7:0], go ? sel : 4'h0};
      interface_sync_call <= slow ? dly[11:8] : (go ? sel : 4'h0);
    end
  end
endmodule
`default_nettype wire

// ---- cpmc_ctrl_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpmc_ctrl_bench;
  import cpmc_pkg::*;
  logic       clk = 1'b0, rst = 1'b1, selector_run = 1'b1, supply_ok = 1'b1, hw_fault = 1'b0;
  logic       pgm_start_req = 1'b0, pgm_stop_req = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic       go = 1'b0, slow = 1'b0, rd_d = 1'b0, irq, links_keep, links_drop, buffers_flush;
  logic       system_jobs_en, programming_device_en, pgm_test_en, db_alter_en, plc_if_en;
  logic       bus_xfer_en, run_indicator, stop_indicator, module_fault_indicator;
  logic       bus_fault_indicator, transceiver_supply_fault_indicator;
  logic [3:0] sel = 4'h0, reg_addr = 4'h0, interface_sync_call;
  logic [6:0] jobs_defined = 7'h01;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, leds, exp_q[$];
  logic [31:0] seed = 32'd29;
  int         fails = 0, compares = 0, cycles = 0;
  assign leds = {4'h0, run_indicator, stop_indicator, module_fault_indicator,
                 transceiver_supply_fault_indicator};
  cpmc_ctrl dut (.clk, .rst, .selector_run, .supply_ok, .hw_fault, .selftest_pass(1'b1),
    .jobs_defined, .active_ifs_m1(2'h1), .interface_sync_call, .pgm_start_req, .pgm_stop_req,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .system_jobs_en, .programming_device_en,
    .pgm_test_en, .db_alter_en, .plc_if_en, .bus_xfer_en, .links_keep, .links_drop, .buffers_flush,
    .run_indicator, .stop_indicator, .module_fault_indicator, .bus_fault_indicator,
    .transceiver_supply_fault_indicator, .irq);
  cpmc_master_model master (.clk, .rst, .go, .slow, .sel, .interface_sync_call);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic test_done;
    if (fails == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
    compares++;
    if (seen !== want) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Register port cycles; a read leaves its expected value for the monitor.
  task automatic rd(input logic [3:0] a, input logic [7:0] want);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(want);
    tick(1);
    reg_rd <= 1'b0;
    tick(1);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    tick(1);
    reg_wr <= 1'b0;
    tick(1);
  endtask
  task automatic pulse(input logic stop);
    pgm_stop_req <= stop;
    pgm_start_req <= !stop;
    tick(1);
    pgm_stop_req <= 1'b0;
    pgm_start_req <= 1'b0;
    tick(1);
  endtask
  task automatic sync(input logic [3:0] s, input logic sl);
    sel <= s;
    slow <= sl;
    go <= 1'b1;
    tick(1);
    go <= 1'b0;
    tick(5);
  endtask
  // Clock of 10 ns.
  initial begin
    forever #5 clk = ~clk;
  end
  // Read data stand one cycle after the strobe; compare with the oldest note.
  always @(posedge clk) begin
    rd_d <= reg_rd;
    cycles++;
    if (rd_d && exp_q.size() > 0) check("reg_rdata", reg_rdata, exp_q.pop_front());
    if (cycles == 1500) begin
      fails++;
      test_done();
    end
  end
  // Main sequence through the modes.
  initial begin
    seed = xs(seed);
    jobs_defined = {4'h0, seed[2:0]} + 7'h01;
    tick(6);
    rst <= 1'b0;
    tick(2);
    rd(CPMC_REG_STATUS, 8'h00);
    check("leds", leds, 8'h04);
    rd(CPMC_REG_MASK, 8'h00);
    wr(CPMC_REG_MASK, {4'h0, seed[7:4]});
    rd(CPMC_REG_MASK, {4'h0, seed[7:4]});
    wr(CPMC_REG_MASK, 8'h01);
    tick(CPMC_TEST_CYC + 12);
    rd(CPMC_REG_STATUS, 8'h02);
    check("leds", leds, 8'h0C);
    sync(4'h1, 1'b1);
    pulse(1'b0);
    tick(12);
    rd(CPMC_REG_STATUS, 8'h02);
    sync(4'h2, 1'b0);
    tick(12);
    rd(CPMC_REG_STATUS, 8'h05);
    check("irq", {7'h00, irq}, 8'h01);
    rd(CPMC_REG_EVENT, 8'h01);
    check("irq", {7'h00, irq}, 8'h00);
    wr(CPMC_REG_CTRL, 8'h01);
    tick(1);
    rd(CPMC_REG_STATUS, 8'h03);
    check("leds", leds, 8'h04);
    pulse(1'b0);
    tick(1);
    check("warm", {6'h00, links_drop, buffers_flush}, 8'h03);
    tick(10);
    rd(CPMC_REG_STATUS, 8'h05);
    pulse(1'b1);
    rd(CPMC_REG_STATUS, 8'h03);
    pulse(1'b0);
    tick(10);
    selector_run <= 1'b0;
    tick(6);
    rd(CPMC_REG_STATUS, 8'h03);
    pulse(1'b0);
    tick(10);
    rd(CPMC_REG_STATUS, 8'h03);
    selector_run <= 1'b1;
    tick(14);
    rd(CPMC_REG_STATUS, 8'h05);
    rd(CPMC_REG_EVENT, 8'h03);
    supply_ok <= 1'b0;
    tick(5);
    check("leds", leds, 8'h09);
    rd(CPMC_REG_EVENT, 8'h08);
    supply_ok <= 1'b1;
    tick(5);
    check("leds", leds, 8'h08);
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00);
    rd(CPMC_REG_MASK, 8'h01);
    hw_fault <= 1'b1;
    tick(5);
    hw_fault <= 1'b0;
    tick(5);
    rd(CPMC_REG_STATUS, 8'h06);
    check("leds", leds, 8'h06);
    rst <= 1'b1;
    tick(6);
    rst <= 1'b0;
    tick(1);
    rd(CPMC_REG_STATUS, 8'h00);
    check("leds", leds, 8'h04);
    tick(2);
    test_done();
  end
endmodule
`default_nettype wire
